// File: mc_ctl_pkg.sv
// Constants for the memory controller channel control and status registers.
// Assumes configuration accesses arrive as single-cycle dword strobes.
//
// Overview of operation
// - Three software-only channel-in-use bits at 10:8, reset zero.
// - Writing 1 to init-complete bit 7 ends training, starts normal work.
// - Init-complete write disables every channel whose in-use bit is clear.
// - Bit 6 selects long mapper pipe for 3- or 6-way interleave only.
// - Bits 5:3 warm-reset channel 2..0 state only.
// - Closed page without autoprecharge bit 2 gives no autoprecharge flag.
// - Error check bit 1: x8 correction in lockstep, else x4.
// - Bit 0 set is closed page; reset zero is open page.
// - Status bit 4 reports error checking enabled, reset one.
// - Off flags 2:0 set by factory fuse or init-complete without in-use.
// - A channel's clocks are gated while its off flag is set.
package mc_ctl_pkg;
    localparam logic [7:0]  CTRL_OFFSET      = 8'h48;
    localparam logic [7:0]  STAT_OFFSET      = 8'h4C;
    localparam int          NUM_CHAN         = 3;
    localparam int          CTRL_IN_USE_LSB  = 8;
    localparam int          CTRL_INIT_DONE   = 7;
    localparam int          CTRL_DIV3        = 6;
    localparam int          CTRL_CH_RST_LSB  = 3;
    localparam int          CTRL_AUTOPRE     = 2;
    localparam int          CTRL_ECC         = 1;
    localparam int          CTRL_CLOSED      = 0;
    localparam int          STAT_ECC_ON      = 4;
    localparam int          STAT_OFF_LSB     = 0;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] STAT_RESET       = 32'h0000_0010;
    localparam logic        ECC_ON_RESET     = 1'b1;
    localparam int          CH_RST_HOLD      = 2;
    localparam logic [1:0]  CH_RST_CYCLES    = 2'(CH_RST_HOLD);
endpackage : mc_ctl_pkg

// File: mc_chan_gate.sv
// Per-channel reset and clock-gate enable stage.
// Assumes the off flag and reset request come from the same clock domain.
`timescale 1ns/1ps
module mc_chan_gate
    import mc_ctl_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_rst_req,
    input  wire logic i_off,
    output logic      o_chan_rst,
    output logic      o_clk_en
);
    logic [1:0] hold_r;

    // --------------------------------------------------------------------
    // Warm reset stretch
    // --------------------------------------------------------------------
    // channel warm reset
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_r     <= 2'h0;
            o_chan_rst <= 1'b1;
        end else begin
            if (i_rst_req) begin
                hold_r <= CH_RST_CYCLES;
            end else if (hold_r != 2'h0) begin
                hold_r <= hold_r - 2'h1;
            end
            o_chan_rst <= i_rst_req || (hold_r != 2'h0);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_clk_en <= 1'b0;
        end else begin
            o_clk_en <= ~i_off;
        end
    end

    AST_RST_FOLLOWS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_rst_req |=> o_chan_rst [*3])
        else $error("channel reset not held after request");
    AST_GATE_OFF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_off |=> !o_clk_en)
        else $error("clock enabled while channel off");
endmodule : mc_chan_gate

// File: mc_ctl_regs.sv
// Control and status register pair of the memory controller channels.
// Assumes one-cycle config read/write strobes with dword address on the core clock;
// the fuse disable inputs are static straps from the same domain.
`timescale 1ns/1ps
module mc_ctl_regs
    import mc_ctl_pkg::*;
(
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst,
    input  wire logic                i_cfg_wr,
    input  wire logic                i_cfg_rd,
    input  wire logic [7:0]          i_cfg_addr,
    input  wire logic [31:0]         i_cfg_wdata,
    input  wire logic [NUM_CHAN-1:0] i_fuse_off,
    input  wire logic                i_lockstep,
    input  wire logic                i_ilv_3or6,
    input  wire logic                i_closed_page_access,
    output logic [31:0]              o_cfg_rdata,
    output logic                     o_cfg_rvalid,
    output logic                     o_normal_mode,
    output logic                     o_long_pipe,
    output logic                     o_autopre_flag,
    output logic                     o_closed_page,
    output logic                     o_single_device_data_correction_x8,
    output logic                     o_single_device_data_correction_x4,
    output logic [NUM_CHAN-1:0]      o_chan_in_use,
    output logic [NUM_CHAN-1:0]      o_chan_off,
    output logic [NUM_CHAN-1:0]      o_chan_rst,
    output logic [NUM_CHAN-1:0]      o_chan_clk_en
);
    import mc_ctl_pkg::*;

    typedef enum logic [1:0] {
        ST_TRAIN  = 2'b01,
        ST_NORMAL = 2'b10
    } mode_t;

    mode_t               mode_r;
    logic [NUM_CHAN-1:0] in_use_r;
    logic [NUM_CHAN-1:0] ch_rst_r;
    logic [NUM_CHAN-1:0] off_r;
    logic                div3_r;
    logic                autopre_r;
    logic                ecc_r;
    logic                closed_r;
    logic                ecc_on_r;
    logic                fuse_seen_r;
    logic                ctrl_wr;
    logic                init_pulse;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction : hit

    assign ctrl_wr    = i_cfg_wr && hit(i_cfg_addr, CTRL_OFFSET);
    assign init_pulse = ctrl_wr && i_cfg_wdata[CTRL_INIT_DONE];

    // --------------------------------------------------------------------
    // Control register
    // --------------------------------------------------------------------
    // software-only bits
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            in_use_r  <= CTRL_RESET[CTRL_IN_USE_LSB +: NUM_CHAN];
            div3_r    <= CTRL_RESET[CTRL_DIV3];
            ch_rst_r  <= CTRL_RESET[CTRL_CH_RST_LSB +: NUM_CHAN];
            autopre_r <= CTRL_RESET[CTRL_AUTOPRE];
            ecc_r     <= CTRL_RESET[CTRL_ECC];
            closed_r  <= CTRL_RESET[CTRL_CLOSED];
        end else if (ctrl_wr) begin
            in_use_r  <= i_cfg_wdata[CTRL_IN_USE_LSB +: NUM_CHAN];
            div3_r    <= i_cfg_wdata[CTRL_DIV3];
            ch_rst_r  <= i_cfg_wdata[CTRL_CH_RST_LSB +: NUM_CHAN];
            autopre_r <= i_cfg_wdata[CTRL_AUTOPRE];
            ecc_r     <= i_cfg_wdata[CTRL_ECC];
            closed_r  <= i_cfg_wdata[CTRL_CLOSED];
        end
    end

    // --------------------------------------------------------------------
    // Training / normal mode
    // --------------------------------------------------------------------
    // leave training
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_r <= ST_TRAIN;
        end else begin
            unique case (mode_r)
                ST_TRAIN: begin
                    if (init_pulse) begin
                        mode_r <= ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    mode_r <= ST_NORMAL;
                end
                default: begin
                    mode_r <= ST_TRAIN;
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Channel off flags
    // --------------------------------------------------------------------
    // Straps are caught one edge after release, never under the async reset.
    // The in-use value sampled is the held one ORed with the one in the same write,
    // so software must set in-use bits in an earlier or the same write.
    // disable idle channels
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            off_r       <= STAT_RESET[STAT_OFF_LSB +: NUM_CHAN];
            fuse_seen_r <= 1'b0;
        end else begin
            fuse_seen_r <= 1'b1;
            if (!fuse_seen_r) begin
                off_r <= off_r | i_fuse_off;
            end
            if (init_pulse) begin
                off_r <= off_r | (fuse_seen_r ? 3'h0 : i_fuse_off)
                       | ~(in_use_r | i_cfg_wdata[CTRL_IN_USE_LSB +: NUM_CHAN]);
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ecc_on_r <= ECC_ON_RESET;
        end else begin
            ecc_on_r <= ECC_ON_RESET;
        end
    end

    // --------------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------------
    // write-only reads zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_rdata  <= 32'h0000_0000;
            o_cfg_rvalid <= 1'b0;
        end else begin
            o_cfg_rvalid <= i_cfg_rd;
            o_cfg_rdata  <= 32'h0000_0000;
            if (i_cfg_rd && hit(i_cfg_addr, CTRL_OFFSET)) begin
                o_cfg_rdata[CTRL_IN_USE_LSB +: NUM_CHAN] <= in_use_r;
                o_cfg_rdata[CTRL_DIV3]                   <= div3_r;
                o_cfg_rdata[CTRL_CH_RST_LSB +: NUM_CHAN] <= ch_rst_r;
                o_cfg_rdata[CTRL_AUTOPRE]                <= autopre_r;
                o_cfg_rdata[CTRL_ECC]                    <= ecc_r;
                o_cfg_rdata[CTRL_CLOSED]                 <= closed_r;
            end else if (i_cfg_rd && hit(i_cfg_addr, STAT_OFFSET)) begin
                o_cfg_rdata[STAT_ECC_ON]                 <= ecc_on_r;
                o_cfg_rdata[STAT_OFF_LSB +: NUM_CHAN]    <= off_r;
            end
        end
    end

    // --------------------------------------------------------------------
    // Controller steering outputs
    // --------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_normal_mode  <= 1'b0;
            o_long_pipe    <= 1'b0;
            o_autopre_flag <= 1'b0;
            o_closed_page  <= 1'b0;
            o_single_device_data_correction_x8      <= 1'b0;
            o_single_device_data_correction_x4      <= 1'b0;
            o_chan_in_use  <= 3'h0;
            o_chan_off     <= 3'h0;
        end else begin
            o_normal_mode  <= (mode_r == ST_NORMAL);
            o_long_pipe    <= div3_r && i_ilv_3or6;
            o_autopre_flag <= closed_r && autopre_r && i_closed_page_access;
            o_closed_page  <= closed_r;
            o_single_device_data_correction_x8      <= ecc_r && i_lockstep;
            o_single_device_data_correction_x4      <= ecc_r && !i_lockstep;
            o_chan_in_use  <= in_use_r;
            o_chan_off     <= off_r;
        end
    end

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        mc_chan_gate u_gate (
            .i_sys_clk  (i_sys_clk),
            .i_rst      (i_rst),
            .i_rst_req  (ch_rst_r[c]),
            .i_off      (off_r[c]),
            .o_chan_rst (o_chan_rst[c]),
            .o_clk_en   (o_chan_clk_en[c])
        );
    end

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    AST_IN_USE_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !ctrl_wr |=> in_use_r == $past(in_use_r))
        else $error("in-use bits changed without write");
    AST_INIT_MODE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        init_pulse |=> ##1 o_normal_mode)
        else $error("normal mode not entered after init write");
    AST_OFF_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        init_pulse && !in_use_r[0] && !i_cfg_wdata[CTRL_IN_USE_LSB]
        |=> off_r[0] ##2 !o_chan_clk_en[0])
        else $error("idle channel 0 not disabled");
    AST_OFF_STICKY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        fuse_seen_r && !init_pulse |=> (off_r == $past(off_r)))
        else $error("off flags changed without cause");
    AST_LONG_PIPE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !div3_r |=> !o_long_pipe)
        else $error("long pipe used with enable clear");
    AST_NO_AUTOPRE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        closed_r && !autopre_r |=> !o_autopre_flag)
        else $error("autoprecharge flag without enable");
    AST_SINGLE_DEVICE_DATA_CORRECTION: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ecc_r |=> (o_single_device_data_correction_x8 ^ o_single_device_data_correction_x4))
        else $error("ecc mode not exactly one width");
    AST_ECC_STATUS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_cfg_rd && hit(i_cfg_addr, STAT_OFFSET) |=> o_cfg_rdata[STAT_ECC_ON])
        else $error("ecc status bit not one");
    AST_INIT_RD_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_cfg_rd |=> !o_cfg_rdata[CTRL_INIT_DONE])
        else $error("write-only bit read back nonzero");
    AST_CLOSED: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ##1 o_closed_page == $past(closed_r))
        else $error("page policy output mismatch");

    COV_INIT: cover property (@(posedge i_sys_clk) disable iff (i_rst) init_pulse);
    COV_CH_RST: cover property (@(posedge i_sys_clk) disable iff (i_rst) |o_chan_rst);
    COV_LONG: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_long_pipe);
    COV_X8: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_single_device_data_correction_x8);
endmodule : mc_ctl_regs

// File: tb_memory_ctrl_channel_control_status.sv
// Self-checking bench for the channel control and status register pair.
// Assumes single-cycle config strobes; read data returns one cycle after the read strobe.
`timescale 1ns/1ps
module tb_memory_ctrl_channel_control_status;
    import mc_ctl_pkg::*;
    logic                i_sys_clk = 1'b0;
    logic                i_rst = 1'b1;
    logic                i_cfg_wr = 1'b0;
    logic                i_cfg_rd = 1'b0;
    logic [7:0]          i_cfg_addr = 8'h00;
    logic [31:0]         i_cfg_wdata = 32'h0000_0000;
    logic [NUM_CHAN-1:0] i_fuse_off = 3'h0;
    logic                i_lockstep = 1'b0;
    logic                i_ilv_3or6 = 1'b0;
    logic                i_closed_page_access = 1'b0;
    logic [31:0]         o_cfg_rdata;
    logic                o_cfg_rvalid, o_normal_mode, o_long_pipe, o_autopre_flag;
    logic                o_closed_page, o_single_device_data_correction_x8, o_single_device_data_correction_x4;
    logic [NUM_CHAN-1:0] o_chan_in_use, o_chan_off, o_chan_rst, o_chan_clk_en;
    logic [31:0]         exp_q[$], mask_q[$], seed = 32'h60B2, d, r, m, e;
    int                  fails = 0, checks_done = 0, cycles = 0;

    mc_ctl_regs DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr),
        .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
        .i_fuse_off(i_fuse_off), .i_lockstep(i_lockstep), .i_ilv_3or6(i_ilv_3or6),
        .i_closed_page_access(i_closed_page_access), .o_cfg_rdata(o_cfg_rdata),
        .o_cfg_rvalid(o_cfg_rvalid), .o_normal_mode(o_normal_mode),
        .o_long_pipe(o_long_pipe), .o_autopre_flag(o_autopre_flag),
        .o_closed_page(o_closed_page), .o_single_device_data_correction_x8(o_single_device_data_correction_x8), .o_single_device_data_correction_x4(o_single_device_data_correction_x4),
        .o_chan_in_use(o_chan_in_use), .o_chan_off(o_chan_off), .o_chan_rst(o_chan_rst),
        .o_chan_clk_en(o_chan_clk_en));

    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge i_sys_clk);
        i_cfg_wr <= 1'b1;
        i_cfg_addr <= a;
        i_cfg_wdata <= dat;
        @(posedge i_sys_clk);
        i_cfg_wr <= 1'b0;
    endtask : wr

    // Expected value is noted before the strobe so the monitor always finds it
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        exp_q.push_back(exp);
        mask_q.push_back(msk);
        @(posedge i_sys_clk);
        i_cfg_rd <= 1'b1;
        i_cfg_addr <= a;
        @(posedge i_sys_clk);
        i_cfg_rd <= 1'b0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask : settle

    task automatic do_reset(input logic [2:0] fuse);
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        i_fuse_off <= fuse;
        settle(7);
        check(32'(o_chan_rst), 32'h7, "channel reset during reset");
        @(posedge i_sys_clk);
        i_rst <= 1'b0;
    endtask : do_reset

    always @(negedge i_sys_clk) begin
        if (o_cfg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(o_cfg_rdata, 32'hFFFF_FFFF, "read data with nothing expected");
            end else begin
                m = mask_q.pop_front();
                e = exp_q.pop_front();
                check(o_cfg_rdata & m, e & m, "read data");
            end
        end
    end

    // A hang costs a mismatch; the run needs well under a thousand cycles
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(3'h0);
        rd(CTRL_OFFSET, CTRL_RESET, 32'hFFFF_FFFF);
        rd(STAT_OFFSET, STAT_RESET, 32'hFFFF_FFFF);
        settle(2);
        check(32'(o_chan_clk_en), 32'h7, "clock enables after reset");
        check(32'(o_normal_mode), 32'h0, "training after reset");
        $display("test reset done");

        for (int i = 0; i < 12; i++) begin
            d = rnd() & 32'h0000_0747;
            r = rnd();
            wr(CTRL_OFFSET, d);
            i_lockstep <= r[0];
            // interleave level stands in for a consistent decoder
            i_ilv_3or6 <= r[1];
            i_closed_page_access <= r[2];
            settle(2);
            check(32'(o_chan_in_use), 32'(d[10:8]), "in use bits");
            check(32'(o_closed_page), 32'(d[0]), "page policy");
            check(32'(o_long_pipe), 32'(d[6] & r[1]), "long pipe");
            check(32'(o_autopre_flag), 32'(d[0] & d[2] & r[2]), "autoprecharge");
            check(32'(o_single_device_data_correction_x8), 32'(d[1] & r[0]), "x8 correction");
            check(32'(o_single_device_data_correction_x4), 32'(d[1] & ~r[0]), "x4 correction");
            check(32'(o_normal_mode), 32'h0, "still training");
            rd(CTRL_OFFSET, d, 32'hFFFF_FFFF);
        end
        wr(8'h50, 32'h0000_0701);
        wr(STAT_OFFSET, 32'hFFFF_FFFF);
        rd(CTRL_OFFSET, d, 32'hFFFF_FFFF);
        rd(8'h50, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(STAT_OFFSET, STAT_RESET, 32'hFFFF_FFFF);
        $display("test fields done");

        // stimulus keeps software order; only channel 1 named at init
        wr(CTRL_OFFSET, 32'h0000_0000);
        wr(CTRL_OFFSET, 32'h0000_0000 | (32'h1 << CTRL_IN_USE_LSB + 1) | 32'h80);
        settle(3);
        check(32'(o_normal_mode), 32'h1, "normal after init");
        check(32'(o_chan_off), 32'h5, "unused channels off");
        check(32'(o_chan_clk_en), 32'h2, "gated clocks");
        rd(CTRL_OFFSET, 32'h0000_0200, 32'hFFFF_FFFF);
        rd(STAT_OFFSET, STAT_RESET | 32'h0000_0005, 32'hFFFF_FFFF);
        wr(CTRL_OFFSET, 32'h0000_0700);
        settle(2);
        check(32'(o_chan_off), 32'h5, "off flags sticky");
        check(32'(o_normal_mode), 32'h1, "init zero write harmless");
        $display("test init done");

        // local reset of channel 1 only
        wr(CTRL_OFFSET, 32'h0000_0210);
        settle(2);
        check(32'(o_chan_rst), 32'h2, "channel one reset");
        wr(CTRL_OFFSET, 32'h0000_0200);
        settle(CH_RST_HOLD);
        check(32'(o_chan_rst), 32'h2, "reset stretch");
        settle(1);
        check(32'(o_chan_rst), 32'h0, "reset released");
        $display("test channel reset done");

        do_reset(3'h4);
        settle(3);
        check(32'(o_chan_off), 32'h4, "fused channel off");
        check(32'(o_chan_clk_en), 32'h3, "fused channel gated");
        rd(STAT_OFFSET, STAT_RESET | 32'h4, 32'hFFFF_FFFF);
        // closed page set together with autoprecharge
        wr(CTRL_OFFSET, 32'h0000_0105);
        // in-use set by an earlier write still counts at init
        wr(CTRL_OFFSET, 32'h0000_0080);
        settle(3);
        check(32'(o_chan_off), 32'h6, "earlier in-use bit honoured");
        check(32'(o_chan_clk_en), 32'h1, "only channel 0 clocked");
        rd(STAT_OFFSET, STAT_RESET | 32'h0000_0006, 32'hFFFF_FFFF);
        settle(3);
        check(32'(exp_q.size()), 32'h0, "all reads answered");
        $display("test fuse done");
        conclude();
    end
endmodule : tb_memory_ctrl_channel_control_status
